/* hw/dsam_mapper.sv */
/*
 * Direct segment address mapper: holds the user/kernel privilege state
 * and translates the fetch and data addresses, one cycle of latency.
 * Assumes the core pulses excDetect and excReturn for one cycle and
 * drives both address ports synchronously to clk.
 */
// Notes on behaviour
// - Two privilege states; exception enters kernel.
// - Kernel held until exception return executes.
// - User access with MSB set errors.
// - Kernel may access upper half freely.
// - Lower half adds fixed offset 0x40000000.
// - Lower half adds the same offset in kernel.
// - Lower half top 16M reserved, uncached.
// - Cached window maps to zero, cacheable.
// - Uncached window maps to zero, uncached.
// - Top gigabyte is kernel linear segment.
// - Linear segment top 16M reserved, uncached.
// - 0xFF200000-0xFF3FFFFF flagged debug window.
`timescale 1ns/10ps
module dsam_mapper (
    // Clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 clkEn,
    // Privilege events from the pipeline
    input  wire logic                 excDetect,
    input  wire logic                 excReturn,
    // Fetch address port
    input  wire logic                 fetchValid,
    input  wire logic [31:0]          fetchVirt,
    output logic                      fetchOutValid,
    output dsam_pkg::dsam_xlat_t      fetchXlat,
    // Data address port
    input  wire logic                 dataValid,
    input  wire logic [31:0]          dataVirt,
    output logic                      dataOutValid,
    output dsam_pkg::dsam_xlat_t      dataXlat,
    // Current privilege
    output logic                      kernelMode
);
    import dsam_pkg::*;

    // ****************************************************************
    // Translation function
    // ****************************************************************
    // Shared by both ports so fetch and data can never disagree
    function automatic dsam_xlat_t xlate(input logic [31:0] va,
                                         input logic        kern);
        dsam_xlat_t r;
        r = '0;
        if (!va[MSB_POS]) begin
            r.physAddr  = va + USER_PHYS_OFS;
            r.onChipRsv = (va >= USER_RSV_BASE);
            r.cacheable = !r.onChipRsv;
        end else if (va <= CACHED_TOP) begin
            r.physAddr  = va & WINDOW_MASK;
            r.cacheable = 1'b1;
        end else if (va <= UNCACHED_TOP) begin
            r.physAddr  = va & WINDOW_MASK;
            r.cacheable = 1'b0;
        end else begin
            r.physAddr  = va;
            r.onChipRsv = (va >= LINEAR_RSV_BASE);
            r.cacheable = !r.onChipRsv;
            r.debugArea = (va >= DEBUG_BASE) && (va <= DEBUG_TOP);
        end
        r.addrError = va[MSB_POS] && !kern;
        if (r.addrError) begin
            // Refused access: no target, nothing cacheable
            r.physAddr  = '0;
            r.cacheable = 1'b0;
            r.onChipRsv = 1'b0;
            r.debugArea = 1'b0;
        end
        return r;
    endfunction : xlate

    // ****************************************************************
    // Privilege state
    // ****************************************************************
    dsam_mode_t mode_ff;       // Current privilege
    dsam_mode_t nxt_mode;      // Next privilege

    // Next privilege; an exception outranks a return in the same cycle
    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            DSAM_USER: begin
                if (excDetect) begin
                    nxt_mode = DSAM_KERNEL;
                end
            end
            DSAM_KERNEL: begin
                if (!excDetect && excReturn) begin
                    nxt_mode = DSAM_USER;
                end
            end
            default: begin
                nxt_mode = DSAM_KERNEL;
            end
        endcase
    end

    // Register privilege; reset comes up in kernel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= DSAM_KERNEL;
        end else if (clkEn) begin
            mode_ff <= nxt_mode;
        end
    end

    assign kernelMode = (mode_ff == DSAM_KERNEL);

    // ****************************************************************
    // Translation pipeline register
    // ****************************************************************
    logic       fValid_ff;     // Fetch result valid
    logic       dValid_ff;     // Data result valid
    dsam_xlat_t fXlat_ff;      // Fetch result
    dsam_xlat_t dXlat_ff;      // Data result
    logic       nxt_fValid;
    logic       nxt_dValid;
    dsam_xlat_t nxt_fXlat;
    dsam_xlat_t nxt_dXlat;

    // Translate both ports with the privilege in force this cycle
    always_comb begin
        nxt_fValid = fetchValid;
        nxt_dValid = dataValid;
        nxt_fXlat  = fetchValid ? xlate(fetchVirt, kernelMode) : '0;
        nxt_dXlat  = dataValid  ? xlate(dataVirt,  kernelMode) : '0;
    end

    // Register results
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fValid_ff <= 1'b0;
            dValid_ff <= 1'b0;
            fXlat_ff  <= '0;
            dXlat_ff  <= '0;
        end else if (clkEn) begin
            fValid_ff <= nxt_fValid;
            dValid_ff <= nxt_dValid;
            fXlat_ff  <= nxt_fXlat;
            dXlat_ff  <= nxt_dXlat;
        end
    end

    assign fetchOutValid = fValid_ff;
    assign fetchXlat     = fXlat_ff;
    assign dataOutValid  = dValid_ff;
    assign dataXlat      = dXlat_ff;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_exc;
        clkEn && excDetect;
    endsequence

    sequence s_kern_next;
        ##1 kernelMode;
    endsequence

    property p_enter_kernel;
        @(posedge clk) disable iff (!rst_n) s_exc |-> s_kern_next;
    endproperty
    a_enter_kernel: assert property (p_enter_kernel)
        else $error("Exception did not enter kernel");

    property p_stay_kernel;
        @(posedge clk) disable iff (!rst_n)
            kernelMode && !(clkEn && excReturn) |=> kernelMode;
    endproperty
    a_stay_kernel: assert property (p_stay_kernel)
        else $error("Kernel left without return");

    property p_user_err;
        @(posedge clk) disable iff (!rst_n)
            clkEn && dataValid && !kernelMode && dataVirt[31]
            |=> dataOutValid && dataXlat.addrError;
    endproperty
    a_user_err: assert property (p_user_err)
        else $error("User upper access not refused");

    property p_kern_ok;
        @(posedge clk) disable iff (!rst_n)
            clkEn && fetchValid && kernelMode
            |=> !fetchXlat.addrError;
    endproperty
    a_kern_ok: assert property (p_kern_ok)
        else $error("Kernel access refused");

    property p_low_map;
        @(posedge clk) disable iff (!rst_n)
            clkEn && dataValid && !dataVirt[31]
            |=> dataXlat.physAddr == $past(dataVirt) + 32'h4000_0000;
    endproperty
    a_low_map: assert property (p_low_map)
        else $error("Lower half offset wrong");

    property p_cached;
        @(posedge clk) disable iff (!rst_n)
            clkEn && dataValid && kernelMode
            && dataVirt[31:29] == 3'h4
            |=> dataXlat.cacheable
            && dataXlat.physAddr == {3'h0, $past(dataVirt[28:0])};
    endproperty
    a_cached: assert property (p_cached)
        else $error("Cached window mapping wrong");

    property p_uncached;
        @(posedge clk) disable iff (!rst_n)
            clkEn && dataValid && dataVirt[31:29] == 3'h5
            |=> !dataXlat.cacheable;
    endproperty
    a_uncached: assert property (p_uncached)
        else $error("Uncached window cacheable");

    property p_rsv;
        @(posedge clk) disable iff (!rst_n)
            clkEn && fetchValid && kernelMode && fetchVirt[30:24] == 7'h7f
            && fetchVirt[31] == fetchVirt[30]
            |=> fetchXlat.onChipRsv && !fetchXlat.cacheable;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("Reserved area not flagged");

    property p_debug;
        @(posedge clk) disable iff (!rst_n)
            clkEn && fetchValid && kernelMode
            && fetchVirt[31:21] == 11'h7f9
            |=> fetchXlat.debugArea;
    endproperty
    a_debug: assert property (p_debug)
        else $error("Debug window not flagged");

    property p_linear;
        @(posedge clk) disable iff (!rst_n)
            clkEn && fetchValid && kernelMode && fetchVirt[31:30] == 2'h3
            |=> fetchXlat.physAddr == $past(fetchVirt);
    endproperty
    a_linear: assert property (p_linear)
        else $error("Linear segment not identity");

endmodule : dsam_mapper

/* hw/dsam_pkg.sv */
/*
 * Shared constants and carrier types for the direct segment address
 * mapper: segment bases, sizes, offsets and the translation result.
 * Assumes a 32-bit virtual and physical address space.
 */
package dsam_pkg;

    // ****************************************************************
    // Address widths and segment boundaries
    // ****************************************************************
    localparam int          ADDR_W         = 32;               // Address width
    localparam int          MSB_POS        = 31;               // Privilege bit
    localparam logic [31:0] USER_TOP       = 32'h7fff_ffff;    // Lower half end
    localparam logic [31:0] USER_PHYS_OFS  = 32'h4000_0000;    // Lower half offset
    localparam logic [31:0] CACHED_BASE    = 32'h8000_0000;    // Cached window
    localparam logic [31:0] CACHED_TOP     = 32'h9fff_ffff;    // Cached window end
    localparam logic [31:0] UNCACHED_BASE  = 32'ha000_0000;    // Uncached window
    localparam logic [31:0] UNCACHED_TOP   = 32'hbfff_ffff;    // Uncached end
    localparam logic [31:0] LINEAR_BASE    = 32'hc000_0000;    // Linear segment
    localparam logic [31:0] WINDOW_MASK    = 32'h1fff_ffff;    // 512 Mbyte window
    localparam logic [31:0] USER_RSV_BASE  = 32'h7f00_0000;    // Top 16 Mbytes
    localparam logic [31:0] LINEAR_RSV_BASE = 32'hff00_0000;   // Top 16 Mbytes
    localparam logic [31:0] DEBUG_BASE     = 32'hff20_0000;    // Debug window
    localparam logic [31:0] DEBUG_TOP      = 32'hff3f_ffff;    // Debug end

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic {
        DSAM_USER,
        DSAM_KERNEL
    } dsam_mode_t;

    // Translation result of one address port
    typedef struct packed {
        logic [31:0] physAddr;   // Physical address
        logic        cacheable;  // May be cached
        logic        onChipRsv;  // On-chip reserved area
        logic        debugArea;  // Debug monitor / test window
        logic        addrError;  // Privilege violation
    } dsam_xlat_t;

endpackage : dsam_pkg

/* verification/dsam_core_model.sv */
/*
 * Pipeline-side partner of the address mapper: issues fetch and data
 * addresses and the exception events, one request per call.
 * Assumes a free-running clk; drives 1 ns after each rising edge.
 */
`timescale 1ns/10ps
module dsam_core_model (
    // Clock
    input  wire logic        clk,
    // Requests towards the mapper
    output logic             excDetect,
    output logic             excReturn,
    output logic             fetchValid,
    output logic [31:0]      fetchVirt,
    output logic             dataValid,
    output logic [31:0]      dataVirt
);
    // Idle at time zero
    initial begin
        {excDetect, excReturn, fetchValid, dataValid} = 4'h0;
        fetchVirt = 32'h0000_0000;
        dataVirt  = 32'h0000_0000;
    end

    // One rising edge per request, then release the address lines
    task automatic req(input logic fv, input logic [31:0] fa,
                       input logic dv, input logic [31:0] da,
                       input logic ex, input logic rt);
        @(posedge clk);
        #1;
        {fetchValid, dataValid, excDetect, excReturn} = {fv, dv, ex, rt};
        fetchVirt = fa;
        dataVirt  = da;
        @(posedge clk);
        #1;
        {fetchValid, dataValid, excDetect, excReturn} = 4'h0;
        // Released lines show the inverse, never a stale value
        fetchVirt = ~fetchVirt;
        dataVirt  = ~dataVirt;
    endtask : req
endmodule : dsam_core_model

/* verification/dsam_mapper_tb.sv */
/*
 * Self-checking bench of the address mapper: segment table walk in
 * both privilege modes and the mode transitions.
 * Assumes dsam_pkg and dsam_core_model are compiled first.
 */
`timescale 1ns/10ps
module dsam_mapper_tb;
    import dsam_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clk = 1'b0;     // 20 MHz clock
    logic        rst_n = 1'b0;   // Reset, active low
    logic        clkEn = 1'b1;   // Enable, on except in t_freeze
    logic        excDetect, excReturn, fetchValid, dataValid;
    logic [31:0] fetchVirt, dataVirt;
    logic        fetchOutValid, dataOutValid, kernelMode;
    dsam_xlat_t  fetchXlat, dataXlat;
    logic        kern = 1'b1;    // Expected privilege
    int          errTotal = 0;   // Mismatches
    int          checked = 0;    // Comparisons
    // Boundary addresses of every segment
    localparam logic [31:0] ADDRS [16] = '{
        32'h0000_1000, 32'h7eff_ffff, 32'h7f00_0000, 32'h7fff_ffff,
        32'h8000_0000, 32'h9fff_ffff, 32'ha000_0000, 32'hbfff_ffff,
        32'hc000_0000, 32'hfeff_ffff, 32'hff00_0000, 32'hff1f_ffff,
        32'hff20_0000, 32'hff3f_ffff, 32'hff40_0000, 32'hffff_ffff};

    always #25 clk = ~clk;

    dsam_core_model dsam_core_model_inst (.clk(clk),
        .excDetect(excDetect), .excReturn(excReturn),
        .fetchValid(fetchValid), .fetchVirt(fetchVirt),
        .dataValid(dataValid), .dataVirt(dataVirt));
    dsam_mapper dsam_mapper_inst (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .excDetect(excDetect), .excReturn(excReturn),
        .fetchValid(fetchValid), .fetchVirt(fetchVirt),
        .fetchOutValid(fetchOutValid), .fetchXlat(fetchXlat),
        .dataValid(dataValid), .dataVirt(dataVirt),
        .dataOutValid(dataOutValid), .dataXlat(dataXlat),
        .kernelMode(kernelMode));

    // Expected result of one address in one mode
    function automatic dsam_xlat_t expx(logic [31:0] va, logic k);
        dsam_xlat_t r;
        r = '0;
        if (va[31] && !k) r.addrError = 1'b1;
        else if (!va[31]) begin
            r.physAddr  = va + USER_PHYS_OFS;
            r.onChipRsv = (va >= USER_RSV_BASE);
        end else if (va <= UNCACHED_TOP) r.physAddr = va & WINDOW_MASK;
        else begin
            r.physAddr  = va;
            r.onChipRsv = (va >= LINEAR_RSV_BASE);
            r.debugArea = (va >= DEBUG_BASE) && (va <= DEBUG_TOP);
        end
        r.cacheable = !r.addrError && !r.onChipRsv &&
                      !(va >= UNCACHED_BASE && va <= UNCACHED_TOP);
        return r;
    endfunction : expx

    // One comparison
    task automatic chk(string nm, logic [35:0] e, logic [35:0] s);
        checked++;
        if (s !== e) begin
            errTotal++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // One request cycle on both ports, then judge all outputs
    task automatic step(logic fv, logic [31:0] fa, logic dv,
                        logic [31:0] da, logic ex, logic rt);
        logic m;
        m = kern;
        dsam_core_model_inst.req(fv, fa, dv, da, ex, rt);
        if (ex) kern = 1'b1;
        else if (rt) kern = 1'b0;
        chk("fetchOutValid", {35'h0, fv}, {35'h0, fetchOutValid});
        chk("dataOutValid", {35'h0, dv}, {35'h0, dataOutValid});
        chk("fetchXlat", fv ? expx(fa, m) : '0, fetchXlat);
        chk("dataXlat", dv ? expx(da, m) : '0, dataXlat);
        chk("kernelMode", {35'h0, kern}, {35'h0, kernelMode});
    endtask : step

    // Segment walk in kernel, ports given opposite addresses
    task automatic t_kernel;
        for (int i = 0; i < 16; i++)
            step(1'b1, ADDRS[i], 1'b1, ADDRS[15-i], 1'b0, 1'b0);
    endtask : t_kernel

    // Leave kernel mid-access, then walk the table in user mode
    task automatic t_user;
        step(1'b1, ADDRS[15], 1'b1, ADDRS[0], 1'b0, 1'b1);
        for (int i = 0; i < 16; i++)
            step(1'b1, ADDRS[i], 1'b1, ADDRS[15-i], 1'b0, 1'b0);
    endtask : t_user

    // Mode events: exception wins over a return from user mode, only the return leaves kernel
    task automatic t_mode;
        step(1'b0, ADDRS[0], 1'b0, ADDRS[0], 1'b0, 1'b0);
        step(1'b1, ADDRS[4], 1'b0, ADDRS[0], 1'b1, 1'b1);
        for (int i = 0; i < 3; i++)
            step(1'b0, ADDRS[0], 1'b1, ADDRS[8], 1'b0, 1'b0);
        step(1'b0, ADDRS[0], 1'b0, ADDRS[0], 1'b0, 1'b1);
        step(1'b1, ADDRS[13], 1'b1, ADDRS[3], 1'b1, 1'b0);
    endtask : t_mode

    // Enable low: a return is ignored and the last results stand
    task automatic t_freeze;
        step(1'b1, ADDRS[2], 1'b1, ADDRS[6], 1'b0, 1'b0);
        clkEn = 1'b0;
        dsam_core_model_inst.req(1'b1, ADDRS[9], 1'b1, ADDRS[12],
                                 1'b0, 1'b1);
        clkEn = 1'b1;
        chk("heldFetchValid", {35'h0, 1'b1}, {35'h0, fetchOutValid});
        chk("heldFetchXlat", expx(ADDRS[2], 1'b1), fetchXlat);
        chk("heldDataXlat", expx(ADDRS[6], 1'b1), dataXlat);
        chk("heldMode", {35'h0, 1'b1}, {35'h0, kernelMode});
    endtask : t_freeze

    // Reset in mid-run: user mode falls back to kernel, fetch results clear
    task automatic t_reset;
        step(1'b1, ADDRS[1], 1'b0, ADDRS[0], 1'b0, 1'b1);
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        chk("midResetMode", {35'h0, 1'b1}, {35'h0, kernelMode});
        chk("midResetValid", {35'h0, 1'b0}, {35'h0, fetchOutValid});
        chk("midResetXlat", '0, fetchXlat);
        rst_n = 1'b1;
        kern  = 1'b1;
        step(1'b1, ADDRS[4], 1'b1, ADDRS[13], 1'b0, 1'b0);
    endtask : t_reset

    // Verdict and end of run
    task automatic finish_test;
        $display("checked %0d errTotal %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    // Watchdog
    initial begin
        #100000;
        errTotal++;
        finish_test();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        chk("resetMode", {35'h0, 1'b1}, {35'h0, kernelMode});
        chk("resetXlat", '0, fetchXlat);
        #1 rst_n = 1'b1;
        t_kernel();
        t_user();
        t_mode();
        t_freeze();
        t_reset();
        finish_test();
    end
endmodule : dsam_mapper_tb
